/* core/eotr_pkg.sv */
package eotr_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ         = 200_000_000;
   localparam int unsigned TICK_RATE_HZ        = 128;
   localparam int unsigned TICK_CYCLES         = CLK_FREQ_HZ / TICK_RATE_HZ;
   localparam int unsigned RELAY_MIN_OFF_MS    = 27;
   localparam int unsigned RELAY_MIN_OFF_CYCLES =
      (CLK_FREQ_HZ / 1000) * RELAY_MIN_OFF_MS;
   // ------------------------------------------------------------
   // Widths, positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned COUNT_W       = 24;
   localparam int unsigned THRESH_W      = 16;
   localparam int unsigned THRESH_SHIFT  = 8;
   localparam int unsigned BYTE_W        = 8;
   localparam logic [23:0] COUNT_RESET   = 24'h000000;
   localparam logic [23:0] COUNT_FULL    = 24'hFFFFFF;
   localparam logic [15:0] THRESH_RESET  = 16'h0000;
   localparam logic        SRC_KEY       = 1'b0;
   localparam logic        SRC_CMD       = 1'b1;
   // Operating status 0 bit positions
   localparam int unsigned OS0_RELAY_BIT = 0;
   localparam int unsigned OS0_WAKE_BIT  = 1;
   // Operating status 1 bit positions
   localparam int unsigned OS1_SBRES_BIT = 0;
   // ------------------------------------------------------------
   // Relay protection states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      EOTR_RLY_IDLE  = 2'b00,
      EOTR_RLY_TRIP  = 2'b01,
      EOTR_RLY_WAIT  = 2'b10
   } eotr_rly_e;
endpackage

/* core/eotr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module eotr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // ------------------------------------------------------------
   // Two-stage level synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* core/eotr_timer_relay.sv */
// Notes on behaviour
// - Relay stays on during main undervoltage
// - Start-up: key wake or low battery
// - Key low: relay follows relay_on_cmd
// - Key high: relay on unless fault or off time active
// - Relay state readable in operating_status_0
// - Fault turns relay off, retry delayed
// - Minimum off time 27 ms typical
// - Timer runs only when enable pin high
// - Count 1/128 s steps, saturate
// - Counter readable across three byte registers
// - Zero threshold disables compare, 2 s steps
// - Match sets timer_wake_flag and wake
// - Wake clear only when not matching
// - Start source select: key or command
// - Start clears counter and begins counting
// - Standby flag set at power-up, start clears
// - Wake and reads never pause counting
// - Standby power-up zeroes counter, threshold
// - Other resets keep counter value
// - ECU reset clears threshold registers
// - Standby reset halts and zeroes counter
// - Bulk read returns timer status together
`timescale 1ns/1ps
`default_nettype none
module eotr_timer_relay
   import eotr_pkg::*;
#(
   parameter int unsigned TICK_DIV     = eotr_pkg::TICK_CYCLES,
   parameter int unsigned RELAY_OFF_CY = eotr_pkg::RELAY_MIN_OFF_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        ecu_por_n_in,
   input  wire logic        key_pin_in,
   input  wire logic        wake_pin_in,
   input  wire logic        bus_wake_in,
   input  wire logic        timer_enable_pin_in,
   input  wire logic        main_uv_in,
   input  wire logic        bat_low_in,
   input  wire logic        relay_fault_in,
   input  wire logic        startup_in,
   input  wire logic        relay_on_cmd_in,
   input  wire logic        relay_cmd_wr_in,
   input  wire logic        wake_clear_cmd_in,
   input  wire logic        timer_start_cmd_in,
   input  wire logic        start_source_select_in,
   input  wire logic [15:0] threshold_in,
   input  wire logic        threshold_wr_in,
   input  wire logic        timer_bulk_read_in,
   output logic             main_relay_output_out,
   output logic [7:0]       operating_status_0_out,
   output logic [7:0]       operating_status_1_out,
   output logic [7:0]       counter_status_low_out,
   output logic [7:0]       counter_status_mid_out,
   output logic [7:0]       counter_status_high_out,
   output logic [23:0]      timer_bulk_out,
   output logic             timer_bulk_valid_out,
   output logic             timer_wake_out,
   output logic             timer_wake_flag_out,
   output logic             standby_reset_flag_out
);
   import eotr_pkg::*;

   localparam int unsigned TICK_W = $clog2(TICK_DIV + 1);
   localparam int unsigned OFF_W  = $clog2(RELAY_OFF_CY + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
   localparam logic [OFF_W-1:0]  OFF_LAST  = OFF_W'(RELAY_OFF_CY - 1);

   logic [5:0]          pins_s;
   logic                key_s;
   logic                wake_s;
   logic                ten_s;
   logic                uv_s;
   logic                batlow_s;
   logic                fault_s;
   logic                ecu_rst_s;
   logic                key_prev_q;
   logic                start_ev;
   logic [TICK_W-1:0]   tick_q;
   logic                tick;
   logic [COUNT_W-1:0]  count_q;
   logic                running_q;
   logic [THRESH_W-1:0] thresh_q;
   logic                cmp_mode;
   logic                match;
   logic                wake_q;
   logic                sbres_q;
   logic                relay_cmd_q;
   logic                relay_q;
   logic                relay_d;
   eotr_rly_e           rly_q;
   logic [OFF_W-1:0]    off_q;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   eotr_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   ({~ecu_por_n_in, key_pin_in, timer_enable_pin_in,
                    main_uv_in, bat_low_in, relay_fault_in}),
      .sync_out   (pins_s)
   );
   assign key_s    = pins_s[4];
   assign ten_s    = pins_s[3];
   assign uv_s     = pins_s[2];
   assign batlow_s = pins_s[1];
   assign fault_s  = pins_s[0];
   assign wake_s   = wake_pin_in;

   // ECU reset is separate from standby reset; kept off the counter
   assign ecu_rst_s = pins_s[5];

   // ------------------------------------------------------------
   // Start event and tick
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         key_prev_q <= 1'b0;
      end else begin
         key_prev_q <= key_s;
      end
   end

   assign start_ev = ten_s &&
      ((start_source_select_in == SRC_KEY) ? (key_prev_q && !key_s)
                                           : timer_start_cmd_in);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_q <= '0;
      end else if (start_ev || !ten_s || tick_q == TICK_LAST) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end
   assign tick = ten_s && (tick_q == TICK_LAST);

   // ------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------
   // Standby reset is reset_n_in; ECU reset never touches this
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_q   <= COUNT_RESET;
         running_q <= 1'b0;
      end else if (start_ev) begin
         count_q   <= COUNT_RESET;
         running_q <= 1'b1;
      end else if (tick && running_q && count_q != COUNT_FULL) begin
         count_q   <= count_q + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Threshold and comparator
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         thresh_q <= THRESH_RESET;
      end else if (ecu_rst_s) begin
         thresh_q <= THRESH_RESET;
      end else if (threshold_wr_in) begin
         thresh_q <= threshold_in;
      end
   end

   assign cmp_mode = (thresh_q != THRESH_RESET);
   assign match    = cmp_mode &&
      (count_q[COUNT_W-1:THRESH_SHIFT] == thresh_q);

   // Set wins: clear is refused while the match persists anyway
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wake_q <= 1'b0;
      end else if (match) begin
         wake_q <= 1'b1;
      end else if (wake_clear_cmd_in) begin
         wake_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sbres_q <= 1'b1;
      end else if (start_ev) begin
         sbres_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Main relay
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         relay_cmd_q <= 1'b0;
      end else if (startup_in) begin
         relay_cmd_q <= key_s || batlow_s;
      end else if (relay_cmd_wr_in) begin
         relay_cmd_q <= relay_on_cmd_in;
      end
   end

   // Protection off time guards against repetitive switching damage
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rly_q <= EOTR_RLY_IDLE;
         off_q <= '0;
      end else begin
         case (rly_q)
            EOTR_RLY_IDLE: begin
               if (fault_s) begin
                  rly_q <= EOTR_RLY_TRIP;
                  off_q <= '0;
               end
            end
            EOTR_RLY_TRIP: begin
               if (off_q != OFF_LAST) begin
                  off_q <= off_q + 1'b1;
               end else begin
                  rly_q <= EOTR_RLY_WAIT;
               end
            end
            EOTR_RLY_WAIT: begin
               if (!fault_s) begin
                  rly_q <= EOTR_RLY_IDLE;
               end
            end
            default: begin
               rly_q <= EOTR_RLY_IDLE;
            end
         endcase
      end
   end

   // Undervoltage has no effect: relay keeps its last demand
   always_comb begin
      relay_d = (key_s || relay_cmd_q) && (rly_q == EOTR_RLY_IDLE)
                && !fault_s;
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         relay_q <= 1'b0;
      end else begin
         relay_q <= relay_d;
      end
   end

   // ------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         main_relay_output_out   <= 1'b0;
         operating_status_0_out  <= 8'h00;
         operating_status_1_out  <= 8'h00;
         counter_status_low_out  <= 8'h00;
         counter_status_mid_out  <= 8'h00;
         counter_status_high_out <= 8'h00;
         timer_wake_out          <= 1'b0;
         timer_wake_flag_out     <= 1'b0;
         standby_reset_flag_out  <= 1'b0;
      end else begin
         main_relay_output_out   <= relay_q;
         operating_status_0_out  <= 8'h00;
         operating_status_0_out[OS0_RELAY_BIT] <= relay_q;
         operating_status_0_out[OS0_WAKE_BIT]  <= wake_q;
         operating_status_1_out  <= 8'h00;
         operating_status_1_out[OS1_SBRES_BIT] <= sbres_q;
         counter_status_low_out  <= count_q[7:0];
         counter_status_mid_out  <= count_q[15:8];
         counter_status_high_out <= count_q[23:16];
         timer_wake_out          <= match && !wake_q;
         timer_wake_flag_out     <= wake_q;
         standby_reset_flag_out  <= sbres_q;
      end
   end

   // Snapshot of all three bytes at once avoids torn reads
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         timer_bulk_out       <= COUNT_RESET;
         timer_bulk_valid_out <= 1'b0;
      end else begin
         timer_bulk_valid_out <= timer_bulk_read_in;
         if (timer_bulk_read_in) begin
            timer_bulk_out <= count_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   key_forces_on_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (key_s && rly_q == EOTR_RLY_IDLE && !fault_s) |=> relay_q)
      else $error("relay not on with key high");

   cmd_follows_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!key_s && rly_q == EOTR_RLY_IDLE && !fault_s)
      |=> (relay_q == $past(relay_cmd_q)))
      else $error("relay not following command");

   others_ignored_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!key_s && !relay_cmd_q && (wake_s || bus_wake_in)) |=> !relay_q)
      else $error("relay switched by other wake");

   uv_keeps_on_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (uv_s && relay_cmd_q && !fault_s && rly_q == EOTR_RLY_IDLE) |=> relay_q)
      else $error("relay dropped in undervoltage");

   fault_off_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      fault_s |=> !relay_q)
      else $error("relay on during fault");

   status_relay_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      operating_status_0_out[OS0_RELAY_BIT] == $past(relay_q))
      else $error("relay status mismatch");

   count_sat_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (count_q == COUNT_FULL && !start_ev) |=> count_q == COUNT_FULL)
      else $error("counter wrapped");

   start_clear_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      start_ev |=> (count_q == COUNT_RESET && !sbres_q))
      else $error("start did not clear");

   match_wake_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      match |=> wake_q)
      else $error("wake flag not set");

   clear_wake_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (wake_clear_cmd_in && !match) |=> !wake_q)
      else $error("wake flag not cleared");

   zero_thresh_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (thresh_q == THRESH_RESET && !wake_q) |=> !wake_q)
      else $error("compare active at zero");

   ecu_thresh_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      ecu_rst_s |=> thresh_q == THRESH_RESET)
      else $error("threshold kept over ecu reset");

   disabled_hold_a: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      !ten_s |=> $stable(count_q))
      else $error("counter moved while disabled");
endmodule
`default_nettype wire

/* verification/eotr_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eotr_mcu_model (
   input  wire logic        clk_in,
   input  wire logic        sb_flag_in,
   output logic             relay_on_out,
   output logic             relay_wr_out,
   output logic             clear_out,
   output logic             start_out,
   output logic [15:0]      thresh_out,
   output logic             thresh_wr_out,
   output logic             bulk_rd_out
);
   // ------------------------------------------------------------
   // Command strobes
   // ------------------------------------------------------------
   initial begin
      {relay_on_out, relay_wr_out, clear_out, start_out} = 4'h0;
      {thresh_out, thresh_wr_out, bulk_rd_out} = 18'h00000;
   end
   // Data inverts after the strobe, so a late sample is caught
   task automatic cmd(input int k, input logic [15:0] v);
      @(posedge clk_in);
      #1;
      relay_on_out  = v[0];
      thresh_out    = v;
      relay_wr_out  = (k == 0);
      clear_out     = (k == 1);
      start_out     = (k == 2);
      thresh_wr_out = (k == 3);
      bulk_rd_out   = (k == 4);
      @(posedge clk_in);
      #1;
      {relay_wr_out, clear_out, start_out, thresh_wr_out} = 4'h0;
      bulk_rd_out  = 1'b0;
      relay_on_out = ~v[0];
      thresh_out   = ~v;
   endtask
   // Flag read first, since the start wipes it
   task automatic start(output logic sb);
      sb = sb_flag_in;
      cmd(2, 16'h0000);
   endtask
endmodule
`default_nettype wire

/* verification/engine_off_timer_relay_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module engine_off_timer_relay_ctrl_bench;
   // ------------------------------------------------------------
   // Short counts keep the run small
   // ------------------------------------------------------------
   localparam int ROFF = 20;
   logic        clk_in, reset_n_in, ecu_n, key, wkp, bw, ten, uv;
   logic        bat, fault, startup, sel, ron, rwr, wclr, tst;
   logic        thwr, brd, relay, bulkv, wk, wkf, sbf, sb, p;
   logic [15:0] th;
   logic [7:0]  os0, os1, cl, cm, ch;
   logic [23:0] bulk, c0, b;
   int          i, n_mismatch, num_checks;
   eotr_timer_relay #(.TICK_DIV(4), .RELAY_OFF_CY(ROFF)) dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .ecu_por_n_in(ecu_n),
      .key_pin_in(key), .wake_pin_in(wkp), .bus_wake_in(bw),
      .timer_enable_pin_in(ten), .main_uv_in(uv), .bat_low_in(bat),
      .relay_fault_in(fault), .startup_in(startup),
      .relay_on_cmd_in(ron), .relay_cmd_wr_in(rwr),
      .wake_clear_cmd_in(wclr), .timer_start_cmd_in(tst),
      .start_source_select_in(sel), .threshold_in(th),
      .threshold_wr_in(thwr), .timer_bulk_read_in(brd),
      .main_relay_output_out(relay), .operating_status_0_out(os0),
      .operating_status_1_out(os1), .counter_status_low_out(cl),
      .counter_status_mid_out(cm), .counter_status_high_out(ch),
      .timer_bulk_out(bulk), .timer_bulk_valid_out(bulkv),
      .timer_wake_out(wk), .timer_wake_flag_out(wkf),
      .standby_reset_flag_out(sbf));
   eotr_mcu_model mcu (
      .clk_in(clk_in), .sb_flag_in(sbf), .relay_on_out(ron),
      .relay_wr_out(rwr), .clear_out(wclr), .start_out(tst),
      .thresh_out(th), .thresh_wr_out(thwr), .bulk_rd_out(brd));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   always #2.5 clk_in = ~clk_in;
   task automatic check(input logic [23:0] s, input logic [23:0] e,
                        input string m);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   function automatic logic [23:0] cnt();
      return {ch, cm, cl};
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset();
      tick(3);
      check(os1[0], 1'b1, "standby flag");
      check(cnt(), 24'h000000, "counter zero");
      tick(20);
      check(cnt(), 24'h000000, "halted");
      mcu.start(sb);
      check(sb, 1'b1, "flag before start");
      tick(3);
      check(sbf, 1'b0, "flag cleared");
      c0 = cnt();
      mcu.cmd(4, 16'h0000);
      for (i = 0; i < 6 && bulkv !== 1'b1; i++) tick(1);
      check(bulkv, 1'b1, "bulk valid");
      b = bulk;
      check(c0 <= b && b <= c0 + 2, 1'b1, "bulk");
      tick(1);
      check(bulkv, 1'b0, "bulk pulse");
      tick(37 - i);
      check(cnt() - c0, 24'h00000A, "tick rate");
   endtask
   task t_select();
      sel = 1'b0;
      c0 = cnt();
      mcu.start(sb);
      tick(3);
      check(cnt() >= c0, 1'b1, "command ignored");
      key = 1'b1;
      tick(6);
      key = 1'b0;
      tick(8);
      check(cnt() < 24'h000003, 1'b1, "key start");
      sel = 1'b1;
   endtask
   task t_compare();
      mcu.cmd(3, 16'h0000);
      mcu.start(sb);
      p = 1'b0;
      repeat (300) begin
         tick(1);
         p |= wkf;
      end
      check(p, 1'b0, "zero threshold");
      mcu.cmd(3, 16'h0001);
      for (i = 0; i < 1100 && wkf !== 1'b1; i++) begin
         p |= wk;
         tick(1);
      end
      p |= wk;
      check(cm, 8'h01, "match step");
      tick(1);
      check(p | wk, 1'b1, "wake pulse");
      check(os0[1], 1'b1, "status wake");
      mcu.cmd(1, 16'h0000);
      tick(2);
      check(wkf, 1'b1, "clear refused");
      for (i = 0; i < 1100 && cm !== 8'h02; i++) tick(1);
      check(cm, 8'h02, "still counting");
      mcu.cmd(1, 16'h0000);
      tick(3);
      check(wkf, 1'b0, "clear taken");
   endtask
   task t_ecu();
      mcu.start(sb);
      mcu.cmd(3, 16'h0002);
      tick(20);
      c0 = cnt();
      ecu_n = 1'b0;
      tick(5);
      ecu_n = 1'b1;
      tick(4);
      check(cnt() >= c0 + 2, 1'b1, "counter kept");
      for (i = 0; i < 2200 && cm !== 8'h02; i++) tick(1);
      check(cm, 8'h02, "counter reached");
      tick(4);
      check(wkf, 1'b0, "threshold cleared");
      ten = 1'b0;
      tick(5);
      c0 = cnt();
      mcu.start(sb);
      tick(40);
      check(cnt(), c0, "disabled");
      ten = 1'b1;
      tick(12);
      check(cnt() > c0, 1'b1, "enabled");
   endtask
   task t_relay();
      {wkp, bw} = 2'h3;
      mcu.cmd(0, 16'h0001);
      tick(4);
      check(relay, 1'b1, "cmd on");
      check(os0[0], 1'b1, "status on");
      mcu.cmd(0, 16'h0000);
      tick(4);
      check(relay, 1'b0, "cmd off");
      check(os0[0], 1'b0, "status off");
      key = 1'b1;
      tick(6);
      check(relay, 1'b1, "key on");
      key = 1'b0;
      mcu.cmd(0, 16'h0001);
      uv = 1'b1;
      tick(8);
      check(relay, 1'b1, "undervoltage");
      uv = 1'b0;
      fault = 1'b1;
      for (i = 0; i < 8 && relay !== 1'b0; i++) tick(1);
      check(relay, 1'b0, "fault off");
      tick(2);
      fault = 1'b0;
      for (i = 0; i < 40 && relay !== 1'b1; i++) tick(1);
      check(i >= ROFF - 6 && i <= ROFF + 2, 1'b1, "off time");
      fault = 1'b1;
      tick(ROFF + 10);
      check(relay, 1'b0, "held off");
      fault = 1'b0;
      tick(8);
      check(relay, 1'b1, "back on");
      mcu.cmd(0, 16'h0000);
      bat = 1'b1;
      tick(4);
      startup = 1'b1;
      tick(1);
      startup = 1'b0;
      tick(5);
      check(relay, 1'b1, "startup low bat");
      bat = 1'b0;
      tick(4);
      startup = 1'b1;
      tick(1);
      startup = 1'b0;
      tick(5);
      check(relay, 1'b0, "startup bat ok");
   endtask
   task t_sbreset();
      mcu.cmd(3, 16'h0001);
      reset_n_in = 1'b0;
      tick(2);
      reset_n_in = 1'b1;
      tick(30);
      check(cnt(), 24'h000000, "zeroed");
      check(sbf, 1'b1, "flag set");
      mcu.start(sb);
      for (i = 0; i < 1100 && cm !== 8'h01; i++) tick(1);
      check(cm, 8'h01, "restart counts");
      tick(4);
      check(wkf, 1'b0, "threshold reset");
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      reset_n_in = 1'b0;
      ecu_n = 1'b1;
      {key, wkp, bw, uv, bat, fault, startup} = 7'h00;
      {ten, sel} = 2'h3;
      n_mismatch = 0;
      num_checks = 0;
      repeat (6) @(posedge clk_in);
      #1;
      reset_n_in = 1'b1;
      t_reset();
      t_select();
      t_compare();
      t_ecu();
      t_relay();
      t_sbreset();
      stop_test();
   end
   initial begin
      #(20000 * 5);
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
